// >>> include/cnt_array_pkg.sv
// Package: constants of the counter array with capture modules
//
// Contract
// - Counter advances only while the run bit is set; clearing it stops counting.
// - With idle-stop set, counter halts during processor idle and resumes afterwards.
// - Every overflow sets the overflow flag; flag with its enable requests interrupt. Here no flag is set if a counter byte write lands in the overflow cycle.
// - Hardware never clears the overflow flag; only a software zero write does.
// - Each module flag is set by hardware on a capture.
// - Software clears a module flag by writing zero to it.
// - A module captures whenever either or both edge enables are set.
// - In capture mode the module pin is sampled and transitions are qualified.
// - A valid transition copies counter high and low bytes into capture registers.
// - Module flag together with module interrupt enable requests an interrupt.
package cnt_array_pkg;

    // Widths
    localparam int NUM_MOD = 2;
    localparam int CNT_W = 16;
    localparam int BYTE_W = 8;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_MODE = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_CNT_LO = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_CNT_HI = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_MMODE_BASE = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_MMODE_STEP = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_CAP_BASE = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_CAP_STEP = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_CAP_HI = 8'h04;

    // Field positions
    localparam int CTRL_OVF_BIT = 7;
    localparam int CTRL_RUN_BIT = 6;
    localparam int MODE_IDLE_BIT = 7;
    localparam int MODE_OVFIE_BIT = 0;
    localparam int MM_RISE_BIT = 5;
    localparam int MM_FALL_BIT = 4;
    localparam int MM_IE_BIT = 0;

    // Reset and limit values
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

endpackage

// >>> rtl/in_sync.sv
// Two-stage synchroniser for asynchronous pins
`timescale 1ns/100ps
module in_sync
#(
    parameter int W = cnt_array_pkg::NUM_MOD
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Pins in, synchronised levels out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed
    {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } sync_state_t;

    sync_state_t state_ff;
    sync_state_t nxt_state;

    always_comb
    begin
        nxt_state = state_ff;
        nxt_state.meta = d;
        nxt_state.sync = state_ff.meta;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign q = state_ff.sync;
endmodule

// >>> rtl/capture_module.sv
// Capture module: edge qualification and counter latch
`timescale 1ns/100ps
module capture_module
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Synchronised pin and mode
    input wire logic pin,
    input wire logic rise_en,
    input wire logic fall_en,
    // Counter and results
    input wire logic [cnt_array_pkg::CNT_W-1:0] count,
    output logic evt,
    output logic [cnt_array_pkg::CNT_W-1:0] cap
);
    import cnt_array_pkg::*;

    typedef struct packed
    {
        logic prev;
        logic evt;
        logic [CNT_W-1:0] cap;
    } cap_state_t;

    cap_state_t state_ff;
    cap_state_t nxt_state;
    logic rise;
    logic fall;
    logic valid;

    assign rise = pin && !state_ff.prev;
    assign fall = !pin && state_ff.prev;
    assign valid = (rise && rise_en) || (fall && fall_en);

    always_comb
    begin
        nxt_state = state_ff;
        nxt_state.prev = pin;
        nxt_state.evt = valid;
        if (valid)
        begin
            nxt_state.cap = count;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign evt = state_ff.evt;
    assign cap = state_ff.cap;

    // Checks
    property p_no_mode;
        @(posedge clk) disable iff (rst)
        (!rise_en && !fall_en) |=> !evt;
    endproperty
    a_no_mode: assert property (p_no_mode) else $error("event without capture mode");

    property p_edge_sel;
        @(posedge clk) disable iff (rst)
        ((pin && !state_ff.prev && rise_en) || (!pin && state_ff.prev && fall_en)) |=> evt;
    endproperty
    a_edge_sel: assert property (p_edge_sel) else $error("enabled edge not captured");

    property p_cap_load;
        @(posedge clk) disable iff (rst)
        $rose(pin) && rise_en |=> evt && (cap == $past(count));
    endproperty
    a_cap_load: assert property (p_cap_load) else $error("capture value wrong");
endmodule

// >>> rtl/counter_array.sv
// Counter array top: APB registers, 16-bit counter, capture modules
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
module counter_array
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [cnt_array_pkg::ADDR_W-1:0] PADDR,
    input wire logic [cnt_array_pkg::DATA_W-1:0] PWDATA,
    output logic [cnt_array_pkg::DATA_W-1:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Processor state and capture pins
    input wire logic IDLE_MODE,
    input wire logic [cnt_array_pkg::NUM_MOD-1:0] MODULE_EXTERNAL_INPUT,
    // Interrupt
    output logic IRQ
);
    import cnt_array_pkg::*;

    typedef struct packed
    {
        logic [CNT_W-1:0] cnt;
        logic run;
        logic ovf;
        logic [NUM_MOD-1:0] mflag;
        logic idle_stop;
        logic ovf_ie;
        logic [NUM_MOD-1:0] rise_en;
        logic [NUM_MOD-1:0] fall_en;
        logic [NUM_MOD-1:0] mod_ie;
        logic rdy;
        logic err;
        logic [DATA_W-1:0] rdata;
        logic irq;
    } state_t;

    state_t state_ff;
    state_t nxt_state;
    logic [NUM_MOD-1:0] pin_sync;
    logic [NUM_MOD-1:0] cap_evt;
    logic [CNT_W-1:0] cap_val [NUM_MOD];
    logic access;
    logic done;
    logic wr_done;
    logic ctrl_wr;
    logic tick;
    logic cnt_wr;
    logic ovf_evt;
    logic mapped;
    logic [DATA_W-1:0] rd_val;

    // Address match
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    // Offset of a per-module register
    function automatic logic [ADDR_W-1:0] mod_off(
        input logic [ADDR_W-1:0] base,
        input logic [ADDR_W-1:0] step,
        input int idx
    );
        mod_off = ADDR_W'(int'(base) + idx * int'(step));
    endfunction

    // Pin synchronisers
    in_sync #(.W(NUM_MOD)) u_sync
    (
        .clk(CLK_SYS),
        .rst(SYS_RST),
        .d(MODULE_EXTERNAL_INPUT),
        .q(pin_sync)
    );

    // Capture modules
    generate
        for (genvar i = 0; i < NUM_MOD; i++)
        begin : g_mod
            capture_module u_cap
            (
                .clk(CLK_SYS),
                .rst(SYS_RST),
                .pin(pin_sync[i]),
                .rise_en(state_ff.rise_en[i]),
                .fall_en(state_ff.fall_en[i]),
                .count(state_ff.cnt),
                .evt(cap_evt[i]),
                .cap(cap_val[i])
            );
        end
    endgenerate

    // Bus phases and counter control
    assign access = PSEL && PENABLE;
    assign done = access && state_ff.rdy;
    assign wr_done = done && PWRITE;
    assign ctrl_wr = wr_done && hit(PADDR, OFF_CTRL);
    assign cnt_wr = wr_done && (hit(PADDR, OFF_CNT_LO) || hit(PADDR, OFF_CNT_HI));
    assign tick = state_ff.run && !(state_ff.idle_stop && IDLE_MODE);
    assign ovf_evt = tick && !cnt_wr && (state_ff.cnt == CNT_MAX);

    // Read decode
    always_comb
    begin
        mapped = 1'b0;
        rd_val = '0;
        if (hit(PADDR, OFF_CTRL))
        begin
            mapped = 1'b1;
            rd_val[CTRL_OVF_BIT] = state_ff.ovf;
            rd_val[CTRL_RUN_BIT] = state_ff.run;
            rd_val[NUM_MOD-1:0] = state_ff.mflag;
        end
        if (hit(PADDR, OFF_MODE))
        begin
            mapped = 1'b1;
            rd_val[MODE_IDLE_BIT] = state_ff.idle_stop;
            rd_val[MODE_OVFIE_BIT] = state_ff.ovf_ie;
        end
        if (hit(PADDR, OFF_CNT_LO))
        begin
            mapped = 1'b1;
            rd_val[BYTE_W-1:0] = state_ff.cnt[BYTE_W-1:0];
        end
        if (hit(PADDR, OFF_CNT_HI))
        begin
            mapped = 1'b1;
            rd_val[BYTE_W-1:0] = state_ff.cnt[CNT_W-1:BYTE_W];
        end
        for (int i = 0; i < NUM_MOD; i++)
        begin
            if (hit(PADDR, mod_off(OFF_MMODE_BASE, OFF_MMODE_STEP, i)))
            begin
                mapped = 1'b1;
                rd_val[MM_RISE_BIT] = state_ff.rise_en[i];
                rd_val[MM_FALL_BIT] = state_ff.fall_en[i];
                rd_val[MM_IE_BIT] = state_ff.mod_ie[i];
            end
            if (hit(PADDR, mod_off(OFF_CAP_BASE, OFF_CAP_STEP, i)))
            begin
                mapped = 1'b1;
                rd_val[BYTE_W-1:0] = cap_val[i][BYTE_W-1:0];
            end
            if (hit(PADDR, mod_off(OFF_CAP_BASE, OFF_CAP_STEP, i) + OFF_CAP_HI))
            begin
                mapped = 1'b1;
                rd_val[BYTE_W-1:0] = cap_val[i][CNT_W-1:BYTE_W];
            end
        end
    end

    // Next state
    always_comb
    begin
        nxt_state = state_ff;
        nxt_state.rdy = access && !state_ff.rdy;
        nxt_state.err = access && !state_ff.rdy && !mapped;
        if (access && !state_ff.rdy)
        begin
            nxt_state.rdata = rd_val;
        end

        // Counter
        if (tick)
        begin
            nxt_state.cnt = CNT_W'(state_ff.cnt + CNT_ONE);
        end
        if (wr_done && hit(PADDR, OFF_CNT_LO))
        begin
            nxt_state.cnt[BYTE_W-1:0] = PWDATA[BYTE_W-1:0];
        end
        if (wr_done && hit(PADDR, OFF_CNT_HI))
        begin
            nxt_state.cnt[CNT_W-1:BYTE_W] = PWDATA[BYTE_W-1:0];
        end

        // Control and status writes
        if (ctrl_wr)
        begin
            nxt_state.run = PWDATA[CTRL_RUN_BIT];
            if (!PWDATA[CTRL_OVF_BIT])
            begin
                nxt_state.ovf = 1'b0;
            end
            nxt_state.mflag = state_ff.mflag & PWDATA[NUM_MOD-1:0];
        end
        if (wr_done && hit(PADDR, OFF_MODE))
        begin
            nxt_state.idle_stop = PWDATA[MODE_IDLE_BIT];
            nxt_state.ovf_ie = PWDATA[MODE_OVFIE_BIT];
        end
        for (int i = 0; i < NUM_MOD; i++)
        begin
            if (wr_done && hit(PADDR, mod_off(OFF_MMODE_BASE, OFF_MMODE_STEP, i)))
            begin
                nxt_state.rise_en[i] = PWDATA[MM_RISE_BIT];
                nxt_state.fall_en[i] = PWDATA[MM_FALL_BIT];
                nxt_state.mod_ie[i] = PWDATA[MM_IE_BIT];
            end
        end

        // Hardware set wins over software clear
        if (ovf_evt)
        begin
            nxt_state.ovf = 1'b1;
        end
        nxt_state.mflag = nxt_state.mflag | cap_evt;

        // Interrupt request
        nxt_state.irq = (nxt_state.ovf && nxt_state.ovf_ie) ||
            (|(nxt_state.mflag & nxt_state.mod_ie));
    end

    always_ff @(posedge CLK_SYS or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            state_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // Outputs
    assign PRDATA = state_ff.rdata;
    assign PREADY = state_ff.rdy;
    assign PSLVERR = state_ff.err;
    assign IRQ = state_ff.irq;

    // Checks
    property p_run_stop;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        (!state_ff.run && !cnt_wr) |=> (state_ff.cnt == $past(state_ff.cnt));
    endproperty
    a_run_stop: assert property (p_run_stop) else $error("counter moved while stopped");

    property p_run_adv;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        (state_ff.run && !IDLE_MODE && !cnt_wr) |=>
            (state_ff.cnt == CNT_W'($past(state_ff.cnt) + CNT_ONE));
    endproperty
    a_run_adv: assert property (p_run_adv) else $error("counter did not advance");

    property p_idle_halt;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        (state_ff.idle_stop && IDLE_MODE && !cnt_wr) |=> $stable(state_ff.cnt);
    endproperty
    a_idle_halt: assert property (p_idle_halt) else $error("counter ran during idle");

    property p_wrap;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        (tick && !cnt_wr && state_ff.cnt == CNT_MAX) |=> (state_ff.cnt == CNT_RST) && state_ff.ovf;
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap or overflow flag wrong");

    property p_ovf_irq;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        (state_ff.ovf && state_ff.ovf_ie) |-> IRQ;
    endproperty
    a_ovf_irq: assert property (p_ovf_irq) else $error("overflow interrupt missing");

    property p_ovf_hold;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        (state_ff.ovf && !(ctrl_wr && !PWDATA[CTRL_OVF_BIT])) |=> state_ff.ovf;
    endproperty
    a_ovf_hold: assert property (p_ovf_hold) else $error("overflow flag lost");

    property p_mod_set;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        (cap_evt != '0) |=> ((state_ff.mflag & $past(cap_evt)) == $past(cap_evt));
    endproperty
    a_mod_set: assert property (p_mod_set) else $error("module flag not set");

    property p_mod_clr;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        (ctrl_wr && cap_evt == '0) |=>
            (state_ff.mflag == ($past(state_ff.mflag) & $past(PWDATA[NUM_MOD-1:0])));
    endproperty
    a_mod_clr: assert property (p_mod_clr) else $error("module flag clear wrong");

    property p_mod_irq;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        (|(state_ff.mflag & state_ff.mod_ie)) |-> IRQ;
    endproperty
    a_mod_irq: assert property (p_mod_irq) else $error("module interrupt missing");

    property p_ready_wait;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        (access && !PREADY) |=> PREADY;
    endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("access not answered");

    property p_overflow_seen;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        ovf_evt;
    endproperty
    c_overflow_seen: cover property (p_overflow_seen);

    property p_capture_seen;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        cap_evt != '0;
    endproperty
    c_capture_seen: cover property (p_capture_seen);

    property p_irq_seen;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        $rose(IRQ);
    endproperty
    c_irq_seen: cover property (p_irq_seen);
endmodule

// >>> verif/pin_source.sv
// Partner model: external source driving the capture pins
`timescale 1ns/100ps
module pin_source
#(
    parameter int DLY = 2
)
(
    // Clock
    input wire logic clk,
    // Requested levels and driven pins
    input wire logic [1:0] req,
    output logic [1:0] pins
);
    logic [1:0] stage_ff [DLY] = '{default: 2'h0};

    // Pins follow the request after a fixed board delay
    always @(posedge clk)
    begin
        stage_ff[0] <= req;
        for (int i = 1; i < DLY; i++)
        begin
            stage_ff[i] <= stage_ff[i-1];
        end
    end

    assign pins = stage_ff[DLY-1];
endmodule

// >>> verif/counter_array_capture_tb.sv
// Testbench of the counter array with capture modules
`timescale 1ns/100ps
module counter_array_capture_tb;
    import cnt_array_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic idle = 1'b0;
    logic [1:0] pin_req = 2'h0;
    logic [1:0] pins;
    logic irq;
    int num_errors = 0;
    int checks = 0;
    int seed = 32'h1b30;
    logic [33:0] exp_q [$];
    logic [33:0] note;
    logic [15:0] v;
    logic [15:0] cap_exp [2];
    logic [7:0] modes [4] = '{8'h00, 8'h20, 8'h10, 8'h30};
    logic hit;

    always #25 clk = ~clk;

    counter_array dut (.CLK_SYS(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .IDLE_MODE(idle),
        .MODULE_EXTERNAL_INPUT(pins), .IRQ(irq));

    pin_source #(.DLY(2)) src (.clk(clk), .req(pin_req), .pins(pins));

    task automatic end_of_test();
        if (num_errors == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1)
        begin
            num_errors++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= w ? d : 32'h0;
        exp_q.push_back({w, e, d});
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d}, 1'b0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        apb(1'b0, a, {24'h0, x}, 1'b0);
    endtask

    // Scoreboard: oldest note against each completed transfer
    always @(posedge clk)
    begin
        if (psel && penable && pready === 1'b1)
        begin
            note = exp_q.pop_front();
            chk(pslverr === note[32] && (note[33] || prdata === note[31:0]), "apb response");
        end
    end

    initial
    begin
        repeat (40000) @(posedge clk);
        num_errors++;
        end_of_test();
    end

    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(OFF_CTRL, 8'h00);
        rd(OFF_MODE, 8'h00);
        rd(OFF_CNT_HI, 8'h00);
        apb(1'b0, 8'h40, 32'h0, 1'b1);
        apb(1'b1, 8'h40, 32'h5a, 1'b1);
        // Wrap from ffff to 0000
        wr(OFF_CNT_LO, 8'hfe);
        wr(OFF_CNT_HI, 8'hff);
        wr(OFF_CTRL, 8'h40);
        wr(OFF_CTRL, 8'h80);
        rd(OFF_CNT_HI, 8'h00);
        rd(OFF_CTRL, 8'h80);
        chk(irq === 1'b0, "irq while masked");
        wr(OFF_MODE, 8'h01);
        repeat (3) @(posedge clk);
        chk(irq === 1'b1, "overflow irq");
        repeat (20) @(posedge clk);
        rd(OFF_CTRL, 8'h80);
        wr(OFF_CTRL, 8'h00);
        repeat (3) @(posedge clk);
        chk(irq === 1'b0, "overflow irq cleared");
        rd(OFF_CTRL, 8'h00);
        // Idle stop freezes the running counter
        wr(OFF_CNT_LO, 8'h00);
        wr(OFF_CNT_HI, 8'h00);
        wr(OFF_MODE, 8'h80);
        idle <= 1'b1;
        wr(OFF_CTRL, 8'h40);
        repeat (5) @(posedge clk);
        idle <= 1'b0;
        repeat (10) @(posedge clk);
        idle <= 1'b1;
        rd(OFF_CNT_LO, 8'h0a);
        rd(OFF_CNT_HI, 8'h00);
        // Idle without idle-stop: four more ticks before the run bit drops
        wr(OFF_MODE, 8'h00);
        wr(OFF_CTRL, 8'h00);
        rd(OFF_CNT_LO, 8'h0e);
        idle <= 1'b0;
        // Every edge selection on both modules, counter stopped
        cap_exp[0] = 16'h0000;
        cap_exp[1] = 16'h0000;
        for (int m = 0; m < 2; m++)
        begin
            for (int k = 0; k < 4; k++)
            begin
                wr(OFF_MMODE_BASE + 8'(4 * m), modes[k] | 8'h01);
                for (int e = 0; e < 2; e++)
                begin
                    v = 16'($random(seed));
                    wr(OFF_CNT_LO, v[7:0]);
                    wr(OFF_CNT_HI, v[15:8]);
                    wr(OFF_CTRL, 8'h00);
                    pin_req[m] <= (e == 0);
                    repeat (10) @(posedge clk);
                    hit = (e == 0) ? modes[k][5] : modes[k][4];
                    if (hit)
                        cap_exp[m] = v;
                    chk(irq === hit, "module irq");
                    rd(OFF_CTRL, 8'(hit) << m);
                    rd(OFF_CAP_BASE + 8'(8 * m), cap_exp[m][7:0]);
                    rd(OFF_CAP_BASE + 8'(8 * m) + OFF_CAP_HI, cap_exp[m][15:8]);
                end
            end
            wr(OFF_CTRL, 8'h00);
            rd(OFF_CTRL, 8'h00);
        end
        rd(OFF_CNT_LO, v[7:0]);
        repeat (4) @(posedge clk);
        end_of_test();
    end
endmodule
